// >>> rtl/lrw_lane_ctrl.sv
// lane reversal detection, width negotiation and boot sequencing of the port
`timescale 1ns/1ps
// How it works
// - full x8/x4/x2 width: detect reversal, remap, train
// - width settles at smaller advertised width
// - no reversal on downshifted widths, training fails
// - same behaviour for endpoint and root port
// - ready to train within 20 ms
// - stage one start-up makes port active
// - port answers enumeration while stage two loads
// - x4 port with x2 partner uses lanes 0-1
// - lane 0 failure loses link, no recovery
module lrw_lane_ctrl #(
  parameter int NUM_LANES = 8,
  parameter int READY_CYC = lrw_pkg::LRW_READY_CYC,
  parameter int BOOT_CYC = lrw_pkg::LRW_BOOT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // configuration
  input wire logic [3:0] adv_width_in,
  input wire logic root_port_in,
  input wire logic stage1_start_in,
  // partner observations, pin domain
  input wire logic [3:0] partner_width_in,
  input wire lrw_pkg::lrw_rx_ts_t rx_ts_in,
  input wire logic [NUM_LANES-1:0] lane_ok_in,
  // outputs
  output lrw_pkg::lrw_status_t status_out,
  output logic [NUM_LANES*lrw_pkg::LRW_LNUM_W-1:0] lane_map_out,
  output logic [NUM_LANES-1:0] lane_en_out,
  output logic enum_ready_out
);
  import lrw_pkg::*;
  localparam int LW = LRW_LNUM_W;
  localparam int CW = $clog2(READY_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // the reset pin asserts at once but releases through two flip-flops, so
  // every flip-flop below leaves reset on the same edge
  // this adds two cycles to the boot wait, far inside the deadline
  logic rst_n_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_n_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_n_s1_q <= 1'b1;
      rst_n_q <= rst_n_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two flip-flop synchronisers for partner inputs and stage1_start_in; adv_width_in and root_port_in are not synchronised
  logic [3:0] pw_s1_q;
  logic [3:0] pw_q;
  lrw_rx_ts_t ts_s1_q;
  lrw_rx_ts_t ts_q;
  logic [NUM_LANES-1:0] ok_s1_q;
  logic [NUM_LANES-1:0] ok_q;
  logic start_s1_q;
  logic start_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pw_s1_q <= 4'h0;
      pw_q <= 4'h0;
      ts_s1_q <= '0;
      ts_q <= '0;
      ok_s1_q <= '0;
      ok_q <= '0;
      start_s1_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      pw_s1_q <= partner_width_in;
      pw_q <= pw_s1_q;
      ts_s1_q <= rx_ts_in;
      ts_q <= ts_s1_q;
      ok_s1_q <= lane_ok_in;
      ok_q <= ok_s1_q;
      start_s1_q <= stage1_start_in;
      start_q <= start_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // width negotiation: one-hot codes, so the smaller is the highest common
  // bit that both sides support at or below their own maximum
  wire [3:0] adv_mask = {adv_width_in[3], |adv_width_in[3:2], |adv_width_in[3:1],
                         |adv_width_in};
  wire [3:0] pw_mask = {pw_q[3], |pw_q[3:2], |pw_q[3:1], |pw_q};
  wire [3:0] common = adv_mask & pw_mask;
  wire [3:0] neg_width = common[3] ? LRW_W_X8 : common[2] ? LRW_W_X4 :
                         common[1] ? LRW_W_X2 : common[0] ? LRW_W_X1 : LRW_W_NONE;
  wire full_width = (neg_width == adv_width_in) &&
                    ((neg_width == LRW_W_X8) || (neg_width == LRW_W_X4) ||
                     (neg_width == LRW_W_X2));
  wire [3:0] active_n = neg_width; // lanes in use: 1,2,4,8
  // root port and endpoint share this path: no mode dependency
  wire unused_mode = root_port_in;

  ////////////////////////////////////////////////////////////////////////////
  // reversal inference from the lane number seen on physical lane 0
  wire [LW-1:0] l0_num = ts_q.lane_num[LW-1:0];
  wire l0_valid = ts_q.ts_valid[0];
  wire [LW-1:0] top_num = (active_n == LRW_W_X8) ? 3'h7 :
                          (active_n == LRW_W_X4) ? 3'h3 :
                          (active_n == LRW_W_X2) ? 3'h1 : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // the lane number and partner width cross as plain multi-bit levels, so a
  // value counts only once it has held over two edges; costs one cycle
  // a lane 0 that flickers between two numbers therefore never trains
  logic [LW-1:0] l0_num_prev_q;
  logic l0_valid_prev_q;
  logic [3:0] pw_prev_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      l0_num_prev_q <= '0;
      l0_valid_prev_q <= 1'b0;
      pw_prev_q <= 4'h0;
    end else begin
      l0_num_prev_q <= l0_num;
      l0_valid_prev_q <= l0_valid;
      pw_prev_q <= pw_q;
    end
  end
  wire l0_stable = l0_valid_prev_q && (l0_num_prev_q == l0_num) && (pw_prev_q == pw_q);
  wire saw_l0 = l0_valid && l0_stable;
  wire rev_seen = saw_l0 && (l0_num == top_num) && (top_num != 3'h0);
  // downshifted and reversed: partner lane 0 never reaches us
  wire rev_fail = saw_l0 && (l0_num != 3'h0) && !rev_seen;
  wire rev_ok = rev_seen && full_width;
  wire unused_mode_x = 1'b0 & unused_mode;
  wire train_ok = saw_l0 && ((l0_num == 3'h0) || rev_ok) && !unused_mode_x;

  ////////////////////////////////////////////////////////////////////////////
  // lane map and enables
  logic [NUM_LANES*LW-1:0] map_d;
  logic [NUM_LANES-1:0] en_d;
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      wire [LW-1:0] fwd = LW'(g);
      assign map_d[g*LW +: LW] = rev_ok ? (top_num - fwd) : fwd;
      assign en_d[g] = (g < 1) ? (active_n != 4'h0) :
                       (g < 2) ? (active_n[3:1] != 3'h0) :
                       (g < 4) ? (active_n[3:2] != 2'h0) : active_n[3];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  lrw_state_t st_q;
  lrw_state_t st_d;
  logic [CW-1:0] cnt_q;
  logic rev_q;
  logic ready_q;
  logic up_q;
  logic lost_q;
  logic enum_q;
  logic [3:0] width_q;
  logic [NUM_LANES*LW-1:0] map_q;
  logic [NUM_LANES-1:0] en_q;
  wire boot_done = (cnt_q >= CW'(BOOT_CYC));
  wire deadline = (cnt_q >= CW'(READY_CYC - 1));
  wire lane0_fail = !ok_q[0];

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      LRW_ST_RESET: st_d = LRW_ST_BOOT;
      LRW_ST_BOOT: if (boot_done || deadline) st_d = LRW_ST_TRAIN;
      LRW_ST_TRAIN: if (train_ok && start_q && !rev_fail) st_d = LRW_ST_UP;
      LRW_ST_UP: if (lane0_fail) st_d = LRW_ST_LOST;
      LRW_ST_LOST: st_d = LRW_ST_LOST;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= LRW_ST_RESET;
      cnt_q <= '0;
      rev_q <= 1'b0;
      ready_q <= 1'b0;
      up_q <= 1'b0;
      lost_q <= 1'b0;
      enum_q <= 1'b0;
      width_q <= LRW_W_NONE;
      map_q <= '0;
      en_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_q == LRW_ST_BOOT) cnt_q <= cnt_q + CW'(1);
      ready_q <= (st_d == LRW_ST_TRAIN) || (st_d == LRW_ST_UP);
      up_q <= (st_d == LRW_ST_UP);
      lost_q <= (st_d == LRW_ST_LOST);
      // enumeration answered once stage one is active and the link is up
      enum_q <= (st_d == LRW_ST_UP) && start_q;
      if (st_q == LRW_ST_TRAIN && st_d == LRW_ST_UP) begin
        rev_q <= rev_ok;
        width_q <= neg_width;
        map_q <= map_d;
        en_q <= en_d;
      end else if (st_d == LRW_ST_LOST) begin
        // map and reversal flag keep their last values for post-mortem reads
        en_q <= '0;
        width_q <= LRW_W_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs come straight from flip-flops; nothing here is combinational
  assign status_out = '{ready_to_train: ready_q, link_up: up_q, reversed: rev_q,
                        link_lost: lost_q, width: width_q};
  assign lane_map_out = map_q;
  assign lane_en_out = en_q;
  assign enum_ready_out = enum_q;
endmodule

// >>> rtl/lrw_pkg.sv
// package for the lane reversal and width negotiation block
package lrw_pkg;
  // lane widths, one-hot: x1, x2, x4, x8
  localparam logic [3:0] LRW_W_NONE = 4'h0;
  localparam logic [3:0] LRW_W_X1 = 4'h1;
  localparam logic [3:0] LRW_W_X2 = 4'h2;
  localparam logic [3:0] LRW_W_X4 = 4'h4;
  localparam logic [3:0] LRW_W_X8 = 4'h8;
  localparam int LRW_MAX_LANES = 8;
  // timing
  localparam int LRW_CLK_PERIOD_NS = 10;
  localparam int LRW_READY_MS = 20;
  localparam int LRW_READY_CYC = (LRW_READY_MS * 1000000) / LRW_CLK_PERIOD_NS;
  // boot wait before training may start, short and well inside the deadline
  localparam int LRW_BOOT_US = 10;
  localparam int LRW_BOOT_CYC = (LRW_BOOT_US * 1000) / LRW_CLK_PERIOD_NS;
  // lane number field reported in received training sequences
  localparam int LRW_LNUM_W = 3;

  typedef enum logic [4:0] {
    LRW_ST_RESET = 5'h01,
    LRW_ST_BOOT = 5'h02,
    LRW_ST_TRAIN = 5'h04,
    LRW_ST_UP = 5'h08,
    LRW_ST_LOST = 5'h10
  } lrw_state_t;

  // training sequence observations per lane
  typedef struct packed {
    logic [LRW_MAX_LANES-1:0] ts_valid;
    logic [LRW_MAX_LANES*LRW_LNUM_W-1:0] lane_num;
  } lrw_rx_ts_t;

  // link status toward the user side
  typedef struct packed {
    logic ready_to_train;
    logic link_up;
    logic reversed;
    logic link_lost;
    logic [3:0] width;
  } lrw_status_t;
endpackage

// >>> test/lrw_lane_ctrl_properties.sv
// port assertions for the lane control block
`timescale 1ns/1ps
module lrw_lane_ctrl_properties #(parameter int READY_CYC = 100) (
  input wire logic clk_in, arst_n_in, root_port_in, stage1_start_in, enum_ready_out,
  input wire logic [3:0] adv_width_in, partner_width_in,
  input wire lrw_pkg::lrw_rx_ts_t rx_ts_in,
  input wire logic [7:0] lane_ok_in, lane_en_out,
  input wire lrw_pkg::lrw_status_t status_out,
  input wire logic [23:0] lane_map_out
);
  import lrw_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire up = status_out.link_up;
  wire rv = status_out.reversed;
  wire lo = status_out.link_lost;
  wire [3:0] w = status_out.width;
  wire [3:0] c = (adv_width_in < partner_width_in) ? adv_width_in : partner_width_in;
  int n_q;
  // counts idle cycles before training is ready
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in) n_q <= 0;
    else if (status_out.ready_to_train || up || lo) n_q <= 0;
    else n_q <= n_q + 1;
  sequence s_drop;
    up && !lane_ok_in[0];
  endsequence
  a_ready_in_time: assert property (n_q <= READY_CYC) else $error("late");
  a_lost_sticky: assert property (lo |=> lo) else $error("lost cleared");
  a_lost_down: assert property (lo |-> !up) else $error("up when lost");
  a_lane0_loss: assert property (s_drop |-> ##[1:4] lo) else $error("no loss");
  a_width_min: assert property (up |-> w == c) else $error("width");
  a_lanes_used: assert property (up |-> lane_en_out == (8'h01 << w) - 8'h01) else $error("en");
  a_rev_full: assert property (up && rv |-> w == adv_width_in) else $error("rev");
  a_map_lane0: assert property (up |-> lane_map_out[2:0] == (rv ? 3'(w - 4'h1) : 3'h0))
    else $error("map");
  a_enum_up: assert property (enum_ready_out |-> up) else $error("enum");
endmodule
bind lrw_lane_ctrl lrw_lane_ctrl_properties #(.READY_CYC(READY_CYC)) u_props (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .root_port_in(root_port_in),
  .stage1_start_in(stage1_start_in), .enum_ready_out(enum_ready_out),
  .adv_width_in(adv_width_in), .partner_width_in(partner_width_in), .rx_ts_in(rx_ts_in),
  .lane_ok_in(lane_ok_in), .lane_en_out(lane_en_out), .status_out(status_out),
  .lane_map_out(lane_map_out));

// >>> test/lrw_partner.sv
// far-end lane model with optional reversed board wiring
`timescale 1ns/1ps
module lrw_partner (
  input wire logic clk_in,
  input wire logic [3:0] board_in, width_in,
  input wire logic rev_in, send_in,
  output logic [3:0] width_out,
  output lrw_pkg::lrw_rx_ts_t ts_out
);
  import lrw_pkg::*;
  logic [2:0] nz_q = 3'h0;
  always_ff @(posedge clk_in) nz_q <= nz_q + 3'h1;
  assign width_out = width_in;
  // unconnected lanes carry a moving pattern, never a stale number
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      int j;
      logic v;
      j = rev_in ? int'(board_in) - 1 - i : i;
      v = send_in && i < int'(board_in) && j >= 0 && j < int'(width_in);
      ts_out.ts_valid[i] = v;
      ts_out.lane_num[3*i+:3] = v ? 3'(j) : nz_q ^ 3'(i);
    end
  end
endmodule

// >>> test/lrw_lane_ctrl_tb.sv
// self-checking bench for the lane control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module lrw_lane_ctrl_tb;
  import lrw_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] adv = 4'h8, pw = 4'h8, pwid;
  logic rev = 1'b0, root = 1'b0, send = 1'b0, st1 = 1'b0;
  logic [7:0] ok = 8'hFF, en;
  logic [23:0] map;
  logic enr;
  lrw_rx_ts_t ts;
  lrw_status_t st;
  int errors = 0, checks_done = 0, cyc = 0, seed = 78, w, n, up;
  // rev, own width, partner width
  int tab [8] = '{'h188, 'h144, 'h184, 'h042, 'h088, 'h081, 'h122, 'h024};
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  lrw_partner u_far (.clk_in(clk_in), .board_in(adv), .width_in(pw), .rev_in(rev),
    .send_in(send), .width_out(pwid), .ts_out(ts));
  lrw_lane_ctrl #(.NUM_LANES(8), .READY_CYC(100), .BOOT_CYC(4)) dut (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .adv_width_in(adv), .root_port_in(root),
    .stage1_start_in(st1), .partner_width_in(pwid), .rx_ts_in(ts), .lane_ok_in(ok),
    .status_out(st), .lane_map_out(map), .lane_en_out(en), .enum_ready_out(enr));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run_case(input int a, p, r, rt);
    w = (a < p) ? a : p;
    up = (w != 0) && (r == 0 || (w == a && p >= a));
    @(posedge clk_in);
    {arst_n_in, adv, pw, rev, send, st1, ok} <= {1'b0, 4'(a), 4'(p), r[0], 2'b00, 8'hFF};
    root <= rt[0];
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    n = 0;
    while (st.ready_to_train !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    `CHK("ready", 1'b1, n <= 100)
    @(posedge clk_in);
    send <= 1'b1;
    repeat (8) @(negedge clk_in);
    `CHK("early_up", 1'b0, st.link_up)
    `CHK("early_enum", 1'b0, enr)
    @(posedge clk_in);
    st1 <= 1'b1;
    for (n = 0; st.link_up !== 1'b1 && n < 20; n++) @(negedge clk_in);
    `CHK("link_up", up[0], st.link_up)
    if (up != 0) begin
      `CHK("width", 4'(w), st.width)
      `CHK("reversed", (r != 0) && (w > 1), st.reversed)
      `CHK("lane_en", (8'h01 << w) - 8'h01, en)
      `CHK("enum", 1'b1, enr)
      for (int i = 0; i < w; i++) `CHK("map", 3'(r != 0 ? w - 1 - i : i), map[3*i+:3])
    end
    @(posedge clk_in);
    ok <= 8'hFE;
    repeat (6) @(negedge clk_in);
    `CHK("lost", up[0], st.link_lost)
    `CHK("up_after", 1'b0, st.link_up)
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    for (int k = 0; k < 20; k++) begin
      if (k < 16) run_case(tab[k%8] >> 4 & 'hF, tab[k%8] & 'hF, tab[k%8] >> 8, k / 8);
      else run_case(1 << ($random(seed) & 3), 1 << ($random(seed) & 3), $random(seed) & 1, k);
    end
    give_verdict();
  end
endmodule
